// ==== rtl/tweep_pkg.sv ====
// Purpose: shared constants and types for the two-wire eeprom device
// Assumes: byte-wide array, 128-bit serial number held outside it
// Notes:   no bus registers; every setting comes from pins
package tweep_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int          ARRAY_DEPTH_DEF = 256;    // 128 on the small variant
  localparam int          BYTE_W          = 8;
  localparam int          SERIAL_BITS     = 128;
  localparam int          SERIAL_BYTES    = 16;
  localparam int          SERIAL_IDX_W    = 4;
  localparam int          STRAP_W         = 3;

  // ---------------------------------------------------------------------
  // address byte decode and bit counting
  // ---------------------------------------------------------------------
  localparam logic [3:0]  DEV_TYPE_ARRAY  = 4'ha;
  localparam logic [3:0]  DEV_TYPE_SERIAL = 4'hb;
  localparam logic        RW_READ         = 1'h1;
  localparam logic [2:0]  BIT_FIRST       = 3'h0;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic        ACK_LEVEL       = 1'h0;   // controller ack is sda low

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_WADDR,
    S_WDATA,
    S_RDATA,
    S_ACK,
    S_MACK
  } tweep_state_t;

  // static pin levels
  typedef struct packed {
    logic [STRAP_W-1:0] strap;
    logic               wp;
  } tweep_pins_t;

  // first byte of a frame
  typedef struct packed {
    logic [3:0]         dev_type;
    logic [STRAP_W-1:0] strap;
    logic               rw;
  } tweep_hdr_t;

  // one sampled bit handed from the link domain
  typedef struct packed {
    logic               bit_val;
    logic               toggle;
  } tweep_bit_t;

endpackage : tweep_pkg

// ==== rtl/tweep_link.sv ====
// Purpose: serial clock domain of the device; samples and drives sda
// Assumes: scl is the link clock; two scl rises under reset, two after it
// Notes:   one bit per rising edge is handed over with a toggle
`timescale 1ns/10ps
`default_nettype none
module tweep_link
  import tweep_pkg::*;
(
  // link clock and reset
  input  wire logic   scl,
  input  wire logic   rst_n,
  // pin side
  input  wire logic   sda_i,
  // core side
  input  wire logic   drive_low,
  output tweep_bit_t  rx_bit,
  output logic        drive_r
);

  // ---------------------------------------------------------------------
  // reset brought into the scl domain
  // ---------------------------------------------------------------------
  logic               rs1_r;
  logic               rs2_r;
  tweep_bit_t         bit_r;

  // two flops so the link reset never goes metastable
  always_ff @(posedge scl)
  begin
    rs1_r <= rst_n;
    rs2_r <= rs1_r;
  end

  // ---------------------------------------------------------------------
  // sampling and driving
  // ---------------------------------------------------------------------
  // data held stable until the next rise, so the core may read it
  always_ff @(posedge scl)
  begin
    if (!rs2_r)
      bit_r <= '0;
    else
      bit_r <= '{bit_val: sda_i, toggle: ~bit_r.toggle};  // R05
  end

  // output only moves on the falling edge, while scl is low
  always_ff @(negedge scl)
  begin
    if (!rs2_r)
      drive_r <= 1'h0;
    else
      drive_r <= drive_low;  // R06
  end

  assign rx_bit = bit_r;

endmodule : tweep_link
`default_nettype wire

// ==== rtl/tweep_mem.sv ====
// Purpose: user array and fixed serial number store
// Assumes: writes already gated by the caller's protection decision
// Notes:   read data registered every cycle from the current address
`timescale 1ns/10ps
`default_nettype none
module tweep_mem
  import tweep_pkg::*;
#(
  parameter int                     DEPTH      = ARRAY_DEPTH_DEF,
  parameter int                     ADDR_W     = $clog2(DEPTH),
  parameter logic [SERIAL_BITS-1:0] SERIAL_NUM = '0
)
(
  // clock
  input  wire logic              mclk,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [BYTE_W-1:0] wr_data,
  // read port
  input  wire logic              rd_serial,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [BYTE_W-1:0] rd_data_r
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [BYTE_W-1:0] array_r [DEPTH];  // R11
  logic [BYTE_W-1:0] ser_bytes [SERIAL_BYTES];
  logic [BYTE_W-1:0] rd_mux;

  // serial number is constant logic, no write path reaches it
  genvar gi;
  generate
    for (gi = 0; gi < SERIAL_BYTES; gi++)
    begin : g_ser
      assign ser_bytes[gi] = SERIAL_NUM[SERIAL_BITS-1-gi*BYTE_W -: BYTE_W];  // R12
    end
  endgenerate

  // separate store, so no array location is consumed
  assign rd_mux = rd_serial ? ser_bytes[rd_addr[SERIAL_IDX_W-1:0]]
                            : array_r[rd_addr];  // R13

  // array contents carry no reset, as in a real eeprom
  always_ff @(posedge mclk)
  begin
    if (we)
      array_r[wr_addr] <= wr_data;
  end

  always_ff @(posedge mclk)
  begin
    rd_data_r <= rd_mux;
  end

endmodule : tweep_mem
`default_nettype wire

// ==== rtl/tweep_top.sv ====
// Purpose: two-wire eeprom device: pins, frame engine, array, serial number
// Assumes: scl phases last at least six mclk periods inside a frame
// Notes:   write lands in the array as the data byte completes, no busy time
//
// Overview of operation
// R01: three select straps let up to eight devices share one bus.
// R02: respond only when sent select bits equal the strap levels.
// R03: a floating strap reads low through its pull-down.
// R04: sda is open drain; the device only pulls low or releases.
// R05: sda is sampled on every rising scl edge.
// R06: driven sda only changes after a falling scl edge.
// R07: the controller keeps scl high while the bus is idle.
// R08: write protect high refuses every array write, contents unchanged.
// R09: write protect low lets array writes proceed normally.
// R10: a floating write protect reads low, leaving writes enabled.
// R11: the array holds 128 or 256 locations of 8 bits.
// R12: a 128-bit serial number is readable and never written.
// R13: the serial number lies outside the user array.
// R14: straps and write protect are static levels checked at write time.
`timescale 1ns/10ps
`default_nettype none
module tweep_top
  import tweep_pkg::*;
#(
  parameter int                     DEPTH      = ARRAY_DEPTH_DEF,
  // arbitrary value, stands in for the factory serial number
  parameter logic [SERIAL_BITS-1:0] SERIAL_NUM =
    128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
)
(
  // core clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // serial bus
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // static straps
  input  wire logic chip_select_strap_bit0,
  input  wire logic chip_select_strap_bit1,
  input  wire logic chip_select_strap_bit2,
  input  wire logic wp
);

  localparam int ADDR_W = $clog2(DEPTH);

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  tweep_pins_t       pin_s1_r;
  tweep_pins_t       pin_s2_r;
  logic              scl_s1_r;
  logic              scl_s2_r;
  logic              sda_s1_r;
  logic              sda_s2_r;
  logic              sda_d_r;
  logic              tog_s1_r;
  logic              tog_s2_r;
  logic              tog_d_r;
  tweep_bit_t        link_bit;
  logic              link_drive;
  tweep_state_t      st_r;
  tweep_state_t      st_nxt;
  tweep_state_t      nx_r;
  tweep_state_t      nx_nxt;
  logic [2:0]        cnt_r;
  logic [2:0]        cnt_nxt;
  logic [BYTE_W-1:0] sh_r;
  logic [BYTE_W-1:0] sh_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              ser_r;
  logic              ser_nxt;
  logic              drive_r;
  logic              drive_nxt;
  logic              busy_r;
  logic [BYTE_W-1:0] rd_data;
  wire  tweep_pins_t pin_raw;
  wire               start_ev;
  wire               stop_ev;
  wire               bit_ev;
  wire               last_bit;
  wire [BYTE_W-1:0]  rx_byte;
  wire tweep_hdr_t   hdr;
  wire               type_ok;
  wire               hdr_match;
  wire               wr_go;
  wire [ADDR_W-1:0]  addr_inc;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // undriven straps rely on the pad pull-down, so they arrive as low
  assign pin_raw = '{strap: {chip_select_strap_bit2, chip_select_strap_bit1,
                             chip_select_strap_bit0},
                     wp:    wp};  // R01 R03 R10

  // straps and protect are levels; two flops then read freely
  always_ff @(posedge mclk)
  begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;  // R14
  end

  // bus lines watched in the core domain for start and stop only
  always_ff @(posedge mclk)
  begin
    scl_s1_r <= scl;
    scl_s2_r <= scl_s1_r;
    sda_s1_r <= sda_i;
    sda_s2_r <= sda_s1_r;
    sda_d_r  <= sda_s2_r;
  end

  // bit toggle from the link domain
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tog_s1_r <= 1'h0;
      tog_s2_r <= 1'h0;
      tog_d_r  <= 1'h0;
    end
    else
    begin
      tog_s1_r <= link_bit.toggle;
      tog_s2_r <= tog_s1_r;
      tog_d_r  <= tog_s2_r;
    end
  end

  // ---------------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------------
  tweep_link u_link (
    .scl       (scl),
    .rst_n     (rst_n),
    .sda_i     (sda_i),
    .drive_low (drive_r),
    .rx_bit    (link_bit),
    .drive_r   (link_drive)
  );

  // ---------------------------------------------------------------------
  // events and decode
  // ---------------------------------------------------------------------
  // sda moving while scl is high marks frame edges
  assign start_ev = scl_s2_r & sda_d_r & ~sda_s2_r;
  assign stop_ev  = scl_s2_r & ~sda_d_r & sda_s2_r;
  // bit value is stable for a whole scl period after its toggle
  assign bit_ev   = tog_s2_r ^ tog_d_r;  // R05
  assign last_bit = (cnt_r == BIT_LAST);
  assign rx_byte  = {sh_r[BYTE_W-2:0], link_bit.bit_val};
  assign hdr      = tweep_hdr_t'(rx_byte);
  assign type_ok  = (hdr.dev_type == DEV_TYPE_ARRAY) |
                    (hdr.dev_type == DEV_TYPE_SERIAL);
  assign hdr_match = type_ok & (hdr.strap == pin_s2_r.strap);  // R02
  assign addr_inc = addr_r + 1'b1;

  // protect is looked at on the very cycle the byte would land
  assign wr_go = (st_r == S_WDATA) & bit_ev & last_bit & ~ser_r &
                 ~pin_s2_r.wp;  // R08 R09 R14

  // ---------------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------------
  // every bit decision is taken on a rising edge; the link applies it at the
  // next falling edge, so the core has half a bit time to answer
  always_comb
  begin
    st_nxt    = st_r;
    nx_nxt    = nx_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    addr_nxt  = addr_r;
    ser_nxt   = ser_r;
    drive_nxt = drive_r;
    if (start_ev)
    begin
      st_nxt    = S_DEV;
      cnt_nxt   = BIT_FIRST;
      drive_nxt = 1'h0;
    end
    else if (stop_ev)
    begin
      st_nxt    = S_IDLE;
      drive_nxt = 1'h0;
    end
    else if (bit_ev)
    begin
      case (st_r)
        S_DEV, S_WADDR, S_WDATA:
        begin
          sh_nxt  = rx_byte;
          cnt_nxt = cnt_r + 3'h1;
          if (last_bit)
          begin
            st_nxt    = S_ACK;
            drive_nxt = 1'h1;
            if (st_r == S_DEV)
            begin
              ser_nxt = (hdr.dev_type == DEV_TYPE_SERIAL);
              nx_nxt  = (hdr.rw == RW_READ) ? S_RDATA : S_WADDR;
              if (!hdr_match)
              begin
                drive_nxt = 1'h0;  // R02
                nx_nxt    = S_IDLE;
              end
            end
            else if (st_r == S_WADDR)
            begin
              addr_nxt = rx_byte[ADDR_W-1:0];
              nx_nxt   = S_WDATA;
            end
            else if (ser_r | pin_s2_r.wp)
            begin
              drive_nxt = 1'h0;  // R08 R12
              nx_nxt    = S_IDLE;
            end
            else
            begin
              addr_nxt = addr_inc;  // R09
              nx_nxt   = S_WDATA;
            end
          end
        end
        S_ACK:
        begin
          st_nxt    = nx_r;
          cnt_nxt   = BIT_FIRST;
          drive_nxt = 1'h0;
          if (nx_r == S_RDATA)
          begin
            sh_nxt    = rd_data;
            drive_nxt = ~rd_data[BYTE_W-1];
          end
        end
        S_RDATA:
        begin
          cnt_nxt = cnt_r + 3'h1;
          if (last_bit)
          begin
            st_nxt    = S_MACK;
            drive_nxt = 1'h0;
            addr_nxt  = addr_inc;
          end
          else
          begin
            sh_nxt    = {sh_r[BYTE_W-2:0], 1'h0};
            drive_nxt = ~sh_r[BYTE_W-2];
          end
        end
        S_MACK:
        begin
          cnt_nxt = BIT_FIRST;
          if (link_bit.bit_val == ACK_LEVEL)
          begin
            st_nxt    = S_RDATA;
            sh_nxt    = rd_data;
            drive_nxt = ~rd_data[BYTE_W-1];
          end
          else
            st_nxt = S_IDLE;
        end
        default:
        begin
          st_nxt    = S_IDLE;
          drive_nxt = 1'h0;
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r    <= S_IDLE;
      nx_r    <= S_IDLE;
      cnt_r   <= BIT_FIRST;
      sh_r    <= '0;
      addr_r  <= '0;
      ser_r   <= 1'h0;
      drive_r <= 1'h0;
      busy_r  <= 1'h0;
    end
    else
    begin
      st_r    <= st_nxt;
      nx_r    <= nx_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      ser_r   <= ser_nxt;
      drive_r <= drive_nxt;
      busy_r  <= (st_nxt != S_IDLE);
    end
  end

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  tweep_mem #(
    .DEPTH      (DEPTH),
    .ADDR_W     (ADDR_W),
    .SERIAL_NUM (SERIAL_NUM)
  ) u_mem (
    .mclk      (mclk),
    .we        (wr_go),
    .wr_addr   (addr_r),
    .wr_data   (rx_byte),
    .rd_serial (ser_r),
    .rd_addr   (addr_r),
    .rd_data_r (rd_data)
  );

  // ---------------------------------------------------------------------
  // sda pad
  // ---------------------------------------------------------------------
  // never drives high; busy gate frees the line at once on a stop or reset
  assign sda_o  = 1'h0;  // R04
  assign sda_oe = link_drive & busy_r;  // R04 R06

endmodule : tweep_top
`default_nettype wire

// ==== tb/tweep_monitor.sv ====
// Purpose: port-level checks of the two-wire eeprom device
// Assumes: straps and wp stay steady within a frame
// Notes:   frame position rebuilt from scl and sda as sampled on mclk
`timescale 1ns/10ps
`default_nettype none
module tweep_monitor
  import tweep_pkg::*;
(
  // core clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial bus
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // static straps
  input wire logic chip_select_strap_bit0,
  input wire logic chip_select_strap_bit1,
  input wire logic chip_select_strap_bit2,
  input wire logic wp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic       scl_q;
  logic       sda_q;
  logic       acked_r;
  logic [7:0] cnt_r;
  logic [7:0] hdr_r;
  wire        rise  = scl & ~scl_q;
  wire        strt  = scl & scl_q & sda_q & ~sda_i;
  wire [2:0]  strap = {chip_select_strap_bit2, chip_select_strap_bit1,
                       chip_select_strap_bit0};
  wire        wr_ok = acked_r & (hdr_r == {DEV_TYPE_ARRAY, strap, 1'b0}) & ~wp;

  // ---------------------------------------------------------------------
  // frame tracker
  // ---------------------------------------------------------------------
  // rises since start, header byte, and whether the header was answered
  always_ff @(posedge mclk)
  begin
    scl_q <= scl;
    sda_q <= sda_i;
    if (!rst_n || strt)
    begin
      cnt_r   <= 8'h00;
      acked_r <= 1'b0;
    end
    else
    begin
      if (rise && cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01; // saturates so long reads stay harmless
      if (rise && cnt_r < 8'h08)
        hdr_r <= {hdr_r[6:0], sda_i};
      if ($rose(sda_oe))
        acked_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  drain_only_a: assert property (sda_o == 1'b0)
    else $error("sda output not held low");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !sda_oe)
    else $error("sda pulled during reset");
  rise_low_a: assert property ($rose(sda_oe) |-> !scl)
    else $error("sda drive began while scl high");
  hold_high_a: assert property ($rose(scl) |=> $stable(sda_oe) [*4])
    else $error("sda drive moved in scl high phase");
  ack_slot_a: assert property ($rose(sda_oe) && !acked_r |-> cnt_r == 8'h08)
    else $error("header answer not after eighth rise");
  strap_match_a: assert property ($rose(sda_oe) && !acked_r |-> hdr_r[3:1] == strap)
    else $error("answered foreign select bits");
  type_match_a: assert property ($rose(sda_oe) && !acked_r |->
    hdr_r[7:4] == DEV_TYPE_ARRAY || hdr_r[7:4] == DEV_TYPE_SERIAL)
    else $error("answered unknown type nibble");
  protect_nack_a: assert property ($rose(sda_oe) && acked_r && !hdr_r[0] && cnt_r >= 8'h1a
    |-> !wp && hdr_r[7:4] == DEV_TYPE_ARRAY)
    else $error("refused write was answered");
  write_ack_a: assert property ($fell(scl) && cnt_r == 8'h1a && wr_ok |-> ##[0:4] sda_oe)
    else $error("allowed write not answered");
endmodule : tweep_monitor
`default_nettype wire

// ==== tb/tweep_ctrl_model.sv ====
// Purpose: two-wire bus controller model, makes scl and pulls sda
// Assumes: sda wire resolved by the bench with a pull-up
// Notes:   scl paced by a free 30 ns tick and stands high between frames
`timescale 1ns/10ps
`default_nettype none
module tweep_ctrl_model
(
  // bus side
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic tick;
  int   low_ticks;

  // free tick, phase unrelated to mclk
  initial
  begin
    tick = 1'b0;
    #7;
    forever #15 tick = ~tick;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask : wt

  // eight pulses span reset release: the link sync needs rises on both
  // sides of it; of the three rises after release, the first two are never sampled
  initial
  begin
    scl       = 1'b1;
    sda_pull  = 1'b0;
    low_ticks = 8;
    wt(2);
    repeat (8)
    begin
      scl = 1'b0;
      wt(2);
      scl = 1'b1;
      wt(2);
    end
  end

  // one bit: data set early in low phase, line sampled mid high phase
  task automatic bit_x(input logic b, output logic s);
    wt(2);
    sda_pull = ~b;
    wt(low_ticks);
    scl = 1'b1;
    wt(4);
    s = sda;
    wt(6);
    scl = 1'b0;
  endtask : bit_x

  // also serves as repeated start from a low scl
  task automatic start_x;
    wt(2);
    sda_pull = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b1;
    wt(8);
    scl = 1'b0;
  endtask : start_x

  task automatic stop_x;
    wt(2);
    sda_pull = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(8);
    sda_pull = 1'b0;
    wt(8);
  endtask : stop_x

  // r[8] is the level seen in the ninth slot
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [8:0] r);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(last, r[8]);
  endtask : byte_x
endmodule : tweep_ctrl_model
`default_nettype wire

// ==== tb/tweep_top_tb_top.sv ====
// Purpose: self-checking bench of the two-wire eeprom device
// Assumes: small array variant, serial number value arbitrary
// Notes:   each byte pushes its expected slot value, a watcher compares
`timescale 1ns/10ps
`default_nettype none
module tweep_top_tb_top
  import tweep_pkg::*;
;
  localparam int                     DEPTH = 128;
  localparam logic [SERIAL_BITS-1:0] SNUM  = 128'h3c5a_9e71_04b8_d2f6_6a1c_e953_b07d_284f;
  logic        mclk, rst_n, scl, pull, s_float, wp_float, wp_r;
  logic [2:0]  strap_r, st;
  logic [15:0] lfsr;
  logic [8:0]  seen;
  logic [8:0]  exp_q[$];
  int          fail_count, total_checks, cyc;
  event        got;
  tri0 [2:0]   strap_w;
  tri0         wp_w;
  wire         sda_w, sda_o, sda_oe;

  // floating straps and wp fall to their pull-downs
  assign strap_w = s_float ? 3'bzzz : strap_r;
  assign wp_w    = wp_float ? 1'bz : wp_r;
  assign sda_w   = ~((sda_oe & ~sda_o) | pull);

  tweep_top #(.DEPTH(DEPTH), .SERIAL_NUM(SNUM)) dut (
    .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_select_strap_bit0(strap_w[0]),
    .chip_select_strap_bit1(strap_w[1]), .chip_select_strap_bit2(strap_w[2]),
    .wp(wp_w));
  tweep_ctrl_model m (.scl(scl), .sda_pull(pull), .sda(sda_w));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input logic [8:0] got_v, input logic [8:0] exp_v);
    total_checks++;
    if (got_v !== exp_v)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got_v, exp_v);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // one byte plus its ninth slot; the watcher compares
  task automatic xb(input logic [7:0] d, input logic last, input logic [8:0] e);
    logic [8:0] r;
    exp_q.push_back(e);
    m.byte_x(d, last, r);
    seen = r;
    ->got;
  endtask : xb

  task automatic hdr(input logic [3:0] t, input logic rw, input logic ack_e);
    m.start_x();
    xb({t, st, rw}, 1'b1, {ack_e, t, st, rw});
  endtask : hdr

  task automatic wr(input logic [7:0] v, input logic ack_e);
    xb(v, 1'b1, {ack_e, v});
  endtask : wr

  task automatic rd(input logic [7:0] e, input logic last);
    xb(8'hff, last, {last, e});
  endtask : rd

  // set the address then turn round into a read
  task automatic seek(input logic [3:0] t, input logic [7:0] a);
    hdr(t, 1'b0, 1'b0);
    wr(a, 1'b0);
    hdr(t, 1'b1, 1'b0);
  endtask : seek

  // clock and watcher
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
    forever
    begin
      @(got);
      check(seen, exp_q.pop_front());
    end
  // ceiling well above the expected run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      conclude();
    end
  end

  initial
  begin
    logic [7:0] d1, d2;
    lfsr         = lfsr_next(16'h96ac);
    d1           = lfsr[7:0];
    lfsr         = lfsr_next(lfsr);
    d2           = lfsr[7:0];
    strap_r      = lfsr[10:8];
    st           = strap_r;
    rst_n        = 1'b0;
    wp_r         = 1'b0;
    s_float      = 1'b0;
    wp_float     = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    cyc          = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // wait out the controller's scl preamble before the first frame
    repeat (16) @(posedge mclk);
    // write at the top of the array, second byte wraps to zero
    hdr(DEV_TYPE_ARRAY, 1'b0, 1'b0);
    wr(8'h7f, 1'b0);
    wr(d1, 1'b0);
    wr(d2, 1'b0);
    m.stop_x();
    seek(DEV_TYPE_ARRAY, 8'h7f);
    rd(d1, 1'b0);
    rd(d2, 1'b1);
    m.stop_x();
    // every select code and a foreign type; only a match is answered
    for (int i = 0; i < 8; i++)
    begin
      m.start_x();
      xb({DEV_TYPE_ARRAY, i[2:0], 1'b0}, 1'b1, {i[2:0] != st, DEV_TYPE_ARRAY, i[2:0], 1'b0});
      m.stop_x();
    end
    hdr(4'h5, 1'b0, 1'b1);
    m.stop_x();
    // protected write refused, byte keeps its value
    @(posedge mclk) wp_r <= 1'b1;
    repeat (4) @(posedge mclk);
    hdr(DEV_TYPE_ARRAY, 1'b0, 1'b0);
    wr(8'h7f, 1'b0);
    wr(~d1, 1'b1);
    m.stop_x();
    @(posedge mclk) wp_r <= 1'b0;
    repeat (4) @(posedge mclk);
    seek(DEV_TYPE_ARRAY, 8'h7f);
    rd(d1, 1'b1);
    m.stop_x();
    // serial store with a slow controller: writes refused, all bytes read
    m.low_ticks = 20;
    hdr(DEV_TYPE_SERIAL, 1'b0, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h55, 1'b1);
    m.stop_x();
    seek(DEV_TYPE_SERIAL, 8'h00);
    for (int k = 0; k < SERIAL_BYTES; k++)
      rd(SNUM[127 - 8 * k -: 8], k == SERIAL_BYTES - 1);
    m.stop_x();
    m.low_ticks = 8;
    seek(DEV_TYPE_ARRAY, 8'h00);
    rd(d2, 1'b1);
    m.stop_x();
    // floating straps and wp read low, writes stay enabled
    @(posedge mclk) s_float <= 1'b1;
    wp_float <= 1'b1;
    st = 3'h0;
    repeat (4) @(posedge mclk);
    hdr(DEV_TYPE_ARRAY, 1'b0, 1'b0);
    wr(8'h05, 1'b0);
    wr(d1, 1'b0);
    m.stop_x();
    seek(DEV_TYPE_ARRAY, 8'h05);
    rd(d1, 1'b1);
    m.stop_x();
    conclude();
  end
endmodule : tweep_top_tb_top

bind tweep_top tweep_monitor u_mon (
  .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .chip_select_strap_bit0(chip_select_strap_bit0),
  .chip_select_strap_bit1(chip_select_strap_bit1),
  .chip_select_strap_bit2(chip_select_strap_bit2), .wp(wp));
`default_nettype wire
